// file: shared/slcd_pkg.sv
// Shared constants and types for the segment LCD serial controller
package slcd_pkg;

  // Frame field lengths, in serial bits
  localparam logic [3:0] ID_BITS = 4'h3;
  localparam logic [3:0] CMD_BITS = 4'h9;
  localparam logic [3:0] ADDR_BITS = 4'h7;
  localparam logic [3:0] DATA_BITS = 4'h4;

  // Mode IDs
  localparam logic [2:0] ID_CMD = 3'h4;
  localparam logic [2:0] ID_WRITE = 3'h5;
  localparam logic [2:0] ID_READ = 3'h6;

  // Display memory geometry
  localparam int SEG_COUNT = 48;
  localparam int COM_COUNT = 8;
  localparam int RAM_WORDS = 96;
  localparam logic [6:0] ADDR_LAST = 7'h5F;

  // Command codes, upper eight bits of the nine-bit code
  localparam logic [7:0] CMD_OSC_HALT = 8'h00;
  localparam logic [7:0] CMD_OSC_RUN = 8'h01;
  localparam logic [7:0] CMD_BIAS_OFF = 8'h02;
  localparam logic [7:0] CMD_BIAS_ON = 8'h03;
  localparam logic [7:0] CMD_TB_OUT_OFF = 8'h04;
  localparam logic [7:0] CMD_WD_FLAG_OFF = 8'h05;
  localparam logic [7:0] CMD_TB_FLAG_ON = 8'h06;
  localparam logic [7:0] CMD_WD_FLAG_ON = 8'h07;
  localparam logic [7:0] CMD_TONE_STOP = 8'h08;
  localparam logic [7:0] CMD_TONE_START = 8'h09;
  localparam logic [7:0] CMD_WD_CLEAR = 8'b0000_111?;
  localparam logic [7:0] CMD_TB_CLEAR = 8'b0000_11??;
  localparam logic [7:0] CMD_CLK_RC = 8'b0001_10??;
  localparam logic [7:0] CMD_CLK_EXT = 8'b0001_11??;
  localparam logic [7:0] CMD_HIGH_PITCH = 8'b010?_????;
  localparam logic [7:0] CMD_LOW_PITCH = 8'b011?_????;
  localparam logic [7:0] CMD_FLAG_PIN_OFF = 8'b100?_0???;
  localparam logic [7:0] CMD_FLAG_PIN_ON = 8'b100?_1???;
  localparam logic [7:0] CMD_RATE = 8'b101?_????;
  localparam logic [7:0] CMD_TEST = 8'hE0;
  localparam logic [7:0] CMD_NORMAL = 8'hE3;

  // Power-on values
  localparam logic [2:0] RATE_RESET = 3'h7;
  localparam logic OSC_ON_RESET = 1'b0;
  localparam logic BIAS_ON_RESET = 1'b0;
  localparam logic TONE_ON_RESET = 1'b0;
  localparam logic FLAG_EN_RESET = 1'b0;
  localparam logic EXT_CLK_RESET = 1'b0;
  localparam logic TEST_RESET = 1'b0;

  // Timing
  localparam int SYS_CLK_HZ = 200000000;
  localparam int OSC_HZ = 32000;
  localparam int OSC_TICK_CYCLES = SYS_CLK_HZ / OSC_HZ;
  localparam int HIGH_PITCH_HZ = 4000;
  localparam int LOW_PITCH_HZ = 2000;
  localparam logic [3:0] HIGH_HALF_TICKS = 4'(OSC_HZ / (2 * HIGH_PITCH_HZ));
  localparam logic [3:0] LOW_HALF_TICKS = 4'(OSC_HZ / (2 * LOW_PITCH_HZ));
  localparam int LCD_FRAME_HZ = 64;
  localparam logic [6:0] SCAN_TICKS = 7'(OSC_HZ / (LCD_FRAME_HZ * COM_COUNT));

  typedef enum logic [2:0] {PH_ID, PH_CMD, PH_ADDR, PH_DATA, PH_SKIP} slcd_phase_t;
  typedef enum logic [1:0] {EV_CMD, EV_ADDR, EV_DATA} slcd_evt_t;

endpackage : slcd_pkg

// file: rtl/slcd_ctrl.sv
// Serial command interpreter, display memory, time base, watchdog and tone logic
`timescale 1ns/1ps
// Functional notes
// - Traffic accepted only while select is low
// - Write strobe rising edge samples one bit
// - Read strobe falling edge drives next bit
// - Data line driven only in read access
// - Mode ID 100 starts command frame
// - ID 110 reads, ID 101 writes/modifies
// - 48x8 memory, 7-bit nibble address
// - Even nibble commons 0-3, odd 4-7
// - Nibble address increments after each nibble
// - Panel scanned over eight commons, 1/8
// - Eight-stage time base, divided oscillator clock
// - Watchdog adds two stages, sets flag
// - Watchdog clear resets both; timer clear one
// - Flag-on enables timer; flag-off disables it
// - Last flag-on command picks time base MSB or watchdog flag for pin
// - Flag pin gated globally, off at reset
// - Flag pin is open drain, low active
// - Tone 2 or 4 kHz, start/stop commands
// - Tone outputs complementary while running
// - Tone outputs low when stopped or down
// - Bias off plus oscillator halt powers down
// - Address MSB first, data LSB first
// - Command is nine bits, last ignored
// - Rate commands pick 125/128..125 Hz, default 125
// - Power-on defaults: halted, off, disabled, normal
module slcd_ctrl #(
  parameter int OSC_TICK_CYCLES = slcd_pkg::OSC_TICK_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic SELECT_N,
  input wire logic WRITE_STROBE_N,
  input wire logic READ_STROBE_N,
  input wire logic DATA_I,
  output logic DATA_O,
  output logic DATA_OE_N,
  output logic FLAG_O,
  output logic FLAG_OE_N,
  output logic TONE_OUT_P,
  output logic TONE_OUT_N,
  output logic [7:0] COMMON_LINES,
  output logic [47:0] SEGMENT_LINES,
  output logic POWER_DOWN,
  output logic EXT_CLK_SEL,
  output logic TEST_MODE
);

  localparam int DIV_W = $clog2(OSC_TICK_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain, clocked by the write strobe

  logic link_rst_n;
  slcd_pkg::slcd_phase_t phase_ff, nxt_phase;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [8:0] shift_ff, nxt_shift;
  logic [2:0] mode_ff, nxt_mode;
  logic evt_tgl_ff, nxt_evt_tgl;
  slcd_pkg::slcd_evt_t evt_kind_ff, nxt_evt_kind;
  logic [8:0] evt_word_ff, nxt_evt_word;
  logic [2:0] evt_mode_ff, nxt_evt_mode;
  logic [8:0] shifted;
  logic [3:0] data_shifted;
  logic [3:0] cnt_inc;

  // Select high holds the frame decoder in reset
  assign link_rst_n = ARST_N & ~SELECT_N;

  always_comb begin
    shifted = {shift_ff[7:0], DATA_I};
    data_shifted = {DATA_I, shift_ff[3:1]};
    cnt_inc = bit_cnt_ff + 4'h1;
    nxt_phase = phase_ff;
    nxt_bit_cnt = cnt_inc;
    nxt_shift = shifted;
    nxt_mode = mode_ff;
    nxt_evt_tgl = evt_tgl_ff;
    nxt_evt_kind = evt_kind_ff;
    nxt_evt_word = evt_word_ff;
    nxt_evt_mode = evt_mode_ff;
    unique case (phase_ff)
      slcd_pkg::PH_ID: begin
        if (cnt_inc == slcd_pkg::ID_BITS) begin
          nxt_bit_cnt = 4'h0;
          nxt_mode = shifted[2:0];
          if (shifted[2:0] == slcd_pkg::ID_CMD) begin
            nxt_phase = slcd_pkg::PH_CMD;
          end else if (shifted[2:0] == slcd_pkg::ID_READ || shifted[2:0] == slcd_pkg::ID_WRITE) begin
            nxt_phase = slcd_pkg::PH_ADDR;
          end else begin
            nxt_phase = slcd_pkg::PH_SKIP;
          end
        end
      end
      slcd_pkg::PH_CMD: begin
        if (cnt_inc == slcd_pkg::CMD_BITS) begin
          nxt_bit_cnt = 4'h0;
          nxt_evt_tgl = ~evt_tgl_ff;
          nxt_evt_kind = slcd_pkg::EV_CMD;
          nxt_evt_word = shifted;
        end
      end
      slcd_pkg::PH_ADDR: begin
        if (cnt_inc == slcd_pkg::ADDR_BITS) begin
          nxt_bit_cnt = 4'h0;
          nxt_phase = slcd_pkg::PH_DATA;
          nxt_evt_tgl = ~evt_tgl_ff;
          nxt_evt_kind = slcd_pkg::EV_ADDR;
          nxt_evt_word = {2'h0, shifted[6:0]};
          nxt_evt_mode = mode_ff;
        end
      end
      slcd_pkg::PH_DATA: begin
        nxt_shift = {5'h00, data_shifted};
        if (cnt_inc == slcd_pkg::DATA_BITS) begin
          nxt_bit_cnt = 4'h0;
          nxt_evt_tgl = ~evt_tgl_ff;
          nxt_evt_kind = slcd_pkg::EV_DATA;
          nxt_evt_word = {5'h00, data_shifted};
        end
      end
      slcd_pkg::PH_SKIP: begin
        nxt_bit_cnt = bit_cnt_ff;
      end
    endcase
  end

  always_ff @(posedge WRITE_STROBE_N or negedge link_rst_n) begin
    if (!link_rst_n) begin
      phase_ff <= slcd_pkg::PH_ID;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 9'h000;
      mode_ff <= 3'h0;
    end else begin
      phase_ff <= nxt_phase;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      mode_ff <= nxt_mode;
    end
  end

  // Event words survive select release so the last unit still crosses
  always_ff @(posedge WRITE_STROBE_N or negedge ARST_N) begin
    if (!ARST_N) begin
      evt_tgl_ff <= 1'b0;
      evt_kind_ff <= slcd_pkg::EV_CMD;
      evt_word_ff <= 9'h000;
      evt_mode_ff <= 3'h0;
    end else begin
      evt_tgl_ff <= nxt_evt_tgl;
      evt_kind_ff <= nxt_evt_kind;
      evt_word_ff <= nxt_evt_word;
      evt_mode_ff <= nxt_evt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system domain

  logic sel_s1_ff, sel_s2_ff, rd_s1_ff, rd_s2_ff, rd_prev_ff;
  logic tgl_s1_ff, tgl_s2_ff, tgl_prev_ff;
  logic evt_seen, rd_fall, rd_rise;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_s1_ff <= 1'b1;
      sel_s2_ff <= 1'b1;
      rd_s1_ff <= 1'b1;
      rd_s2_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_prev_ff <= 1'b0;
    end else begin
      sel_s1_ff <= SELECT_N;
      sel_s2_ff <= sel_s1_ff;
      rd_s1_ff <= READ_STROBE_N;
      rd_s2_ff <= rd_s1_ff;
      rd_prev_ff <= rd_s2_ff;
      tgl_s1_ff <= evt_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_prev_ff <= tgl_s2_ff;
    end
  end

  assign evt_seen = tgl_s2_ff ^ tgl_prev_ff;
  assign rd_fall = rd_prev_ff & ~rd_s2_ff;
  assign rd_rise = ~rd_prev_ff & rd_s2_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Display memory access

  logic [3:0] ram_ff [slcd_pkg::RAM_WORDS];
  logic [3:0] nxt_ram [slcd_pkg::RAM_WORDS];
  logic [6:0] ptr_ff, nxt_ptr, ptr_inc;
  logic [2:0] acc_mode_ff, nxt_acc_mode;
  logic acc_live_ff, nxt_acc_live;
  logic [1:0] rd_bit_ff, nxt_rd_bit;
  logic data_o_ff, nxt_data_o, data_oe_n_ff, nxt_data_oe_n;
  logic [3:0] rd_word;

  always_comb begin
    nxt_ram = ram_ff;
    nxt_ptr = ptr_ff;
    nxt_acc_mode = acc_mode_ff;
    nxt_acc_live = acc_live_ff;
    nxt_rd_bit = rd_bit_ff;
    nxt_data_o = data_o_ff;
    nxt_data_oe_n = data_oe_n_ff;
    ptr_inc = (ptr_ff == slcd_pkg::ADDR_LAST) ? 7'h00 : ptr_ff + 7'h01;
    rd_word = (ptr_ff <= slcd_pkg::ADDR_LAST) ? ram_ff[ptr_ff] : 4'h0;
    if (sel_s2_ff) begin
      nxt_acc_live = 1'b0;
      nxt_rd_bit = 2'h0;
      nxt_data_oe_n = 1'b1;
    end else begin
      if (evt_seen && evt_kind_ff == slcd_pkg::EV_ADDR) begin
        nxt_ptr = evt_word_ff[6:0];
        nxt_acc_mode = evt_mode_ff;
        nxt_acc_live = 1'b1;
        nxt_rd_bit = 2'h0;
      end
      if (evt_seen && evt_kind_ff == slcd_pkg::EV_DATA && acc_live_ff && acc_mode_ff == slcd_pkg::ID_WRITE) begin
        if (ptr_ff <= slcd_pkg::ADDR_LAST) begin
          nxt_ram[ptr_ff] = evt_word_ff[3:0];
        end
        nxt_ptr = ptr_inc;
        nxt_rd_bit = 2'h0;
      end
      if (rd_fall && acc_live_ff) begin
        nxt_data_o = rd_word[rd_bit_ff];
        nxt_data_oe_n = 1'b0;
        nxt_rd_bit = rd_bit_ff + 2'h1;
        if (acc_mode_ff == slcd_pkg::ID_READ && rd_bit_ff == 2'h3) begin
          nxt_ptr = ptr_inc;
        end
      end
      // In modify mode the line turns back to input after each read pulse
      if (rd_rise && acc_mode_ff == slcd_pkg::ID_WRITE) begin
        nxt_data_oe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < slcd_pkg::RAM_WORDS; i++) begin
        ram_ff[i] <= 4'h0;
      end
      ptr_ff <= 7'h00;
      acc_mode_ff <= 3'h0;
      acc_live_ff <= 1'b0;
      rd_bit_ff <= 2'h0;
      data_o_ff <= 1'b1;
      data_oe_n_ff <= 1'b1;
    end else begin
      ram_ff <= nxt_ram;
      ptr_ff <= nxt_ptr;
      acc_mode_ff <= nxt_acc_mode;
      acc_live_ff <= nxt_acc_live;
      rd_bit_ff <= nxt_rd_bit;
      data_o_ff <= nxt_data_o;
      data_oe_n_ff <= nxt_data_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration commands

  logic osc_on_ff, nxt_osc_on, bias_on_ff, nxt_bias_on, tb_en_ff, nxt_tb_en;
  logic src_wd_ff, nxt_src_wd, flag_en_ff, nxt_flag_en, tone_on_ff, nxt_tone_on;
  logic pitch_hi_ff, nxt_pitch_hi, ext_clk_ff, nxt_ext_clk, test_ff, nxt_test;
  logic [2:0] rate_ff, nxt_rate;
  logic tb_clr, wd_clr;
  logic [7:0] cmd;

  always_comb begin
    cmd = evt_word_ff[8:1];
    nxt_osc_on = osc_on_ff;
    nxt_bias_on = bias_on_ff;
    nxt_tb_en = tb_en_ff;
    nxt_src_wd = src_wd_ff;
    nxt_flag_en = flag_en_ff;
    nxt_tone_on = tone_on_ff;
    nxt_pitch_hi = pitch_hi_ff;
    nxt_ext_clk = ext_clk_ff;
    nxt_test = test_ff;
    nxt_rate = rate_ff;
    tb_clr = 1'b0;
    wd_clr = 1'b0;
    if (evt_seen && evt_kind_ff == slcd_pkg::EV_CMD) begin
      casez (cmd)
        slcd_pkg::CMD_OSC_HALT: nxt_osc_on = 1'b0;
        slcd_pkg::CMD_OSC_RUN: nxt_osc_on = 1'b1;
        slcd_pkg::CMD_BIAS_OFF: nxt_bias_on = 1'b0;
        slcd_pkg::CMD_BIAS_ON: nxt_bias_on = 1'b1;
        slcd_pkg::CMD_TB_OUT_OFF: nxt_tb_en = 1'b0;
        slcd_pkg::CMD_WD_FLAG_OFF: nxt_tb_en = 1'b0;
        slcd_pkg::CMD_TB_FLAG_ON: begin
          nxt_tb_en = 1'b1;
          nxt_src_wd = 1'b0;
        end
        slcd_pkg::CMD_WD_FLAG_ON: begin
          nxt_tb_en = 1'b1;
          nxt_src_wd = 1'b1;
        end
        slcd_pkg::CMD_TONE_STOP: nxt_tone_on = 1'b0;
        slcd_pkg::CMD_TONE_START: nxt_tone_on = 1'b1;
        slcd_pkg::CMD_WD_CLEAR: begin
          wd_clr = 1'b1;
          tb_clr = 1'b1;
        end
        slcd_pkg::CMD_TB_CLEAR: tb_clr = 1'b1;
        slcd_pkg::CMD_CLK_RC: nxt_ext_clk = 1'b0;
        slcd_pkg::CMD_CLK_EXT: nxt_ext_clk = 1'b1;
        slcd_pkg::CMD_HIGH_PITCH: nxt_pitch_hi = 1'b1;
        slcd_pkg::CMD_LOW_PITCH: nxt_pitch_hi = 1'b0;
        slcd_pkg::CMD_FLAG_PIN_OFF: nxt_flag_en = 1'b0;
        slcd_pkg::CMD_FLAG_PIN_ON: nxt_flag_en = 1'b1;
        slcd_pkg::CMD_RATE: nxt_rate = cmd[2:0];
        slcd_pkg::CMD_TEST: nxt_test = 1'b1;
        slcd_pkg::CMD_NORMAL: nxt_test = 1'b0;
        default: nxt_test = test_ff;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      osc_on_ff <= slcd_pkg::OSC_ON_RESET;
      bias_on_ff <= slcd_pkg::BIAS_ON_RESET;
      tb_en_ff <= 1'b0;
      src_wd_ff <= 1'b0;
      flag_en_ff <= slcd_pkg::FLAG_EN_RESET;
      tone_on_ff <= slcd_pkg::TONE_ON_RESET;
      pitch_hi_ff <= 1'b0;
      ext_clk_ff <= slcd_pkg::EXT_CLK_RESET;
      test_ff <= slcd_pkg::TEST_RESET;
      rate_ff <= slcd_pkg::RATE_RESET;
    end else begin
      osc_on_ff <= nxt_osc_on;
      bias_on_ff <= nxt_bias_on;
      tb_en_ff <= nxt_tb_en;
      src_wd_ff <= nxt_src_wd;
      flag_en_ff <= nxt_flag_en;
      tone_on_ff <= nxt_tone_on;
      pitch_hi_ff <= nxt_pitch_hi;
      ext_clk_ff <= nxt_ext_clk;
      test_ff <= nxt_test;
      rate_ff <= nxt_rate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator tick, time base, watchdog, tone, scan and pin drivers

  logic [DIV_W-1:0] osc_div_ff, nxt_osc_div;
  logic [6:0] presc_ff, nxt_presc, presc_mask;
  logic [7:0] tb_ff, nxt_tb;
  logic [1:0] wd_ff, nxt_wd;
  logic wd_flag_ff, nxt_wd_flag;
  logic [3:0] tone_div_ff, nxt_tone_div, tone_half;
  logic tone_ph_ff, nxt_tone_ph;
  logic [6:0] scan_div_ff, nxt_scan_div;
  logic [2:0] com_idx_ff, nxt_com_idx;
  logic osc_tick, tb_step, tb_ovf, pwr_down, tone_run;
  logic flag_oe_n_ff, nxt_flag_oe_n, tone_p_ff, nxt_tone_p, tone_n_ff, nxt_tone_n;
  logic [7:0] com_ff, nxt_com;
  logic [47:0] seg_ff, nxt_seg;

  always_comb begin
    pwr_down = ~osc_on_ff & ~bias_on_ff;
    osc_tick = osc_on_ff && osc_div_ff == DIV_W'(OSC_TICK_CYCLES - 1);
    nxt_osc_div = (!osc_on_ff || osc_tick) ? '0 : osc_div_ff + DIV_W'(1);
    presc_mask = 7'h7F >> rate_ff;
    tb_step = osc_tick & tb_en_ff & ((presc_ff & presc_mask) == presc_mask);
    tb_ovf = tb_step & (tb_ff == 8'hFF);
    nxt_presc = (osc_tick && tb_en_ff) ? presc_ff + 7'h01 : presc_ff;
    nxt_tb = tb_step ? tb_ff + 8'h01 : tb_ff;
    nxt_wd = tb_ovf ? wd_ff + 2'h1 : wd_ff;
    if (tb_clr) begin
      nxt_presc = 7'h00;
      nxt_tb = 8'h00;
    end
    if (wd_clr) begin
      nxt_wd = 2'h0;
    end
    // A timeout in the clearing cycle still sets the flag
    nxt_wd_flag = (tb_ovf && wd_ff == 2'h3) ? 1'b1 : (wd_clr ? 1'b0 : wd_flag_ff);
    tone_run = tone_on_ff & ~pwr_down;
    tone_half = pitch_hi_ff ? slcd_pkg::HIGH_HALF_TICKS : slcd_pkg::LOW_HALF_TICKS;
    nxt_tone_div = tone_div_ff;
    nxt_tone_ph = tone_ph_ff;
    if (!tone_run) begin
      nxt_tone_div = 4'h0;
      nxt_tone_ph = 1'b0;
    end else if (osc_tick) begin
      if (tone_div_ff >= tone_half - 4'h1) begin
        nxt_tone_div = 4'h0;
        nxt_tone_ph = ~tone_ph_ff;
      end else begin
        nxt_tone_div = tone_div_ff + 4'h1;
      end
    end
    nxt_tone_p = tone_run & tone_ph_ff;
    nxt_tone_n = tone_run & ~tone_ph_ff;
    nxt_scan_div = scan_div_ff;
    nxt_com_idx = com_idx_ff;
    if (osc_tick) begin
      if (scan_div_ff == slcd_pkg::SCAN_TICKS - 7'h01) begin
        nxt_scan_div = 7'h00;
        nxt_com_idx = com_idx_ff + 3'h1;
      end else begin
        nxt_scan_div = scan_div_ff + 7'h01;
      end
    end
    nxt_com = bias_on_ff ? (8'h01 << com_idx_ff) : 8'h00;
    nxt_flag_oe_n = ~(flag_en_ff & (src_wd_ff ? wd_flag_ff : tb_ff[7]));
  end

  // Each segment shows the bit of its nibble pair for the active common
  for (genvar n = 0; n < slcd_pkg::SEG_COUNT; n++) begin : g_seg
    assign nxt_seg[n] = bias_on_ff &
      (com_idx_ff[2] ? ram_ff[2 * n + 1][com_idx_ff[1:0]] : ram_ff[2 * n][com_idx_ff[1:0]]);
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      osc_div_ff <= '0;
      presc_ff <= 7'h00;
      tb_ff <= 8'h00;
      wd_ff <= 2'h0;
      wd_flag_ff <= 1'b0;
      tone_div_ff <= 4'h0;
      tone_ph_ff <= 1'b0;
      scan_div_ff <= 7'h00;
      com_idx_ff <= 3'h0;
      flag_oe_n_ff <= 1'b1;
      tone_p_ff <= 1'b0;
      tone_n_ff <= 1'b0;
      com_ff <= 8'h00;
      seg_ff <= 48'h0000_0000_0000;
    end else begin
      osc_div_ff <= nxt_osc_div;
      presc_ff <= nxt_presc;
      tb_ff <= nxt_tb;
      wd_ff <= nxt_wd;
      wd_flag_ff <= nxt_wd_flag;
      tone_div_ff <= nxt_tone_div;
      tone_ph_ff <= nxt_tone_ph;
      scan_div_ff <= nxt_scan_div;
      com_idx_ff <= nxt_com_idx;
      flag_oe_n_ff <= nxt_flag_oe_n;
      tone_p_ff <= nxt_tone_p;
      tone_n_ff <= nxt_tone_n;
      com_ff <= nxt_com;
      seg_ff <= nxt_seg;
    end
  end

  // The flag pin only ever pulls low
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      FLAG_O <= 1'b0;
      POWER_DOWN <= 1'b1;
    end else begin
      FLAG_O <= 1'b0;
      POWER_DOWN <= pwr_down;
    end
  end

  assign DATA_O = data_o_ff;
  assign DATA_OE_N = data_oe_n_ff;
  assign FLAG_OE_N = flag_oe_n_ff;
  assign TONE_OUT_P = tone_p_ff;
  assign TONE_OUT_N = tone_n_ff;
  assign COMMON_LINES = com_ff;
  assign SEGMENT_LINES = seg_ff;
  assign EXT_CLK_SEL = ext_clk_ff;
  assign TEST_MODE = test_ff;

endmodule : slcd_ctrl

// file: tb/slcd_ctrl_props.sv
// Port-level checker for the serial LCD controller
`timescale 1ns/1ps
module slcd_ctrl_props #(
  parameter int OSC_TICK_CYCLES = 4
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic SELECT_N,
  input wire logic READ_STROBE_N,
  input wire logic DATA_OE_N,
  input wire logic FLAG_O,
  input wire logic FLAG_OE_N,
  input wire logic TONE_OUT_P,
  input wire logic TONE_OUT_N,
  input wire logic [7:0] COMMON_LINES,
  input wire logic POWER_DOWN,
  input wire logic EXT_CLK_SEL,
  input wire logic TEST_MODE
);
  localparam int HALF_HI = 4 * OSC_TICK_CYCLES;
  localparam int HALF_LO = 8 * OSC_TICK_CYCLES;
  logic first_ff;
  logic p_ff;
  int run_ff;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles the positive tone output has held its level
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      first_ff <= 1'b1;
      p_ff <= 1'b0;
      run_ff <= 0;
    end else begin
      first_ff <= 1'b0;
      p_ff <= TONE_OUT_P;
      run_ff <= (TONE_OUT_P != p_ff) ? 1 : run_ff + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_quiet; SELECT_N [*6]; endsequence
  sequence s_tone_fall; $fell(TONE_OUT_P) && TONE_OUT_N; endsequence
  property p_first; first_ff |-> POWER_DOWN && FLAG_OE_N && DATA_OE_N && !EXT_CLK_SEL && !TEST_MODE; endproperty
  a_first: assert property (p_first) else $error("bad state after reset");
  property p_quiet; s_quiet |=> $stable(TEST_MODE) && $stable(EXT_CLK_SEL) && $stable(POWER_DOWN); endproperty
  a_quiet: assert property (p_quiet) else $error("state moved while deselected");
  property p_release; s_quiet |-> DATA_OE_N; endproperty
  a_release: assert property (p_release) else $error("data line driven while deselected");
  property p_rd_lat; $fell(DATA_OE_N) |-> !$past(READ_STROBE_N, 2); endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("data driven without read strobe");
  property p_od; !FLAG_O; endproperty
  a_od: assert property (p_od) else $error("flag output driven high");
  property p_excl; !(TONE_OUT_P && TONE_OUT_N); endproperty
  a_excl: assert property (p_excl) else $error("tone pair both high");
  property p_half; s_tone_fall |-> $rose(TONE_OUT_N) && (run_ff == HALF_HI || run_ff == HALF_LO); endproperty
  a_half: assert property (p_half) else $error("tone half period wrong");
  property p_down; POWER_DOWN && $past(POWER_DOWN) |-> !TONE_OUT_P && !TONE_OUT_N && COMMON_LINES == 8'h00; endproperty
  a_down: assert property (p_down) else $error("outputs active in power down");
  property p_scan; $onehot0(COMMON_LINES); endproperty
  a_scan: assert property (p_scan) else $error("more than one common active");
endmodule : slcd_ctrl_props

// file: tb/slcd_host.sv
// Host controller model driving the serial link
`timescale 1ns/1ps
module slcd_host (
  input wire logic DATA_O,
  input wire logic DATA_OE_N,
  output logic SELECT_N,
  output logic WRITE_STROBE_N,
  output logic READ_STROBE_N,
  output logic DATA_I
);
  logic drv;
  logic bit_v;
  // Resolved line with pull-up
  assign DATA_I = !DATA_OE_N ? DATA_O : (drv ? bit_v : 1'b1);
  initial begin
    SELECT_N = 1'b1;
    WRITE_STROBE_N = 1'b1;
    READ_STROBE_N = 1'b1;
    drv = 1'b0;
    bit_v = 1'b1;
  end
  // Sends n low bits of v on a 12 ns strobe, first bit v[n-1] or v[0]
  task automatic send(input logic [8:0] v, input int n, input logic lsb);
    for (int k = 0; k < n; k++) begin
      SELECT_N = 1'b0;
      WRITE_STROBE_N = 1'b0;
      drv = 1'b1;
      bit_v = v[lsb ? k : n - 1 - k];
      #6;
      WRITE_STROBE_N = 1'b1;
      #6;
    end
  endtask : send
  task automatic rd(output logic b);
    drv = 1'b0;
    READ_STROBE_N = 1'b0;
    #40;
    b = DATA_I;
    READ_STROBE_N = 1'b1;
    #40;
  endtask : rd
  task automatic done();
    drv = 1'b0;
    #30;
    SELECT_N = 1'b1;
    #30;
  endtask : done
endmodule : slcd_host

// file: tb/tb_slcd_ctrl.sv
// Self-checking bench for the serial LCD controller
`timescale 1ns/1ps
module tb_slcd_ctrl;
  localparam int TICK = 4;
  logic clk_sys, arst_n, sel_n, wr_n, rd_n, dat_i, dat_o, dat_oe_n, flag_o, flag_oe_n;
  logic tone_p, tone_n, pwr_dn, ext_clk, test_m;
  logic [7:0] common;
  logic [47:0] seg;
  logic [15:0] st;
  int err_total;
  int n_compared;
  assign st = {common, flag_oe_n, tone_p, tone_n, pwr_dn, 4'h0};
  slcd_ctrl #(.OSC_TICK_CYCLES(TICK)) u_dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .SELECT_N(sel_n),
    .WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n), .DATA_I(dat_i), .DATA_O(dat_o), .DATA_OE_N(dat_oe_n),
    .FLAG_O(flag_o), .FLAG_OE_N(flag_oe_n), .TONE_OUT_P(tone_p), .TONE_OUT_N(tone_n), .COMMON_LINES(common),
    .SEGMENT_LINES(seg), .POWER_DOWN(pwr_dn), .EXT_CLK_SEL(ext_clk), .TEST_MODE(test_m));
  slcd_host u_host (.DATA_O(dat_o), .DATA_OE_N(dat_oe_n), .SELECT_N(sel_n), .WRITE_STROBE_N(wr_n),
    .READ_STROBE_N(rd_n), .DATA_I(dat_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic await(input logic [15:0] m, input logic [15:0] v, input int lim);
    int k;
    k = 0;
    while ((st & m) !== v && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    if ((st & m) !== v) begin
      err_total++;
      $display("unexpected at %0t: wait expired", $time);
      end_sim();
    end
  endtask : await
  // Length of the next full phase at level v
  task automatic span(input logic [15:0] m, input logic [15:0] v, input int exp);
    int n;
    n = 0;
    await(m, ~v & m, 5000);
    await(m, v, 5000);
    while ((st & m) === v && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n, exp);
  endtask : span
  task automatic cmd(input logic [7:0] c);
    u_host.send(9'h004, 3, 1'b0);
    u_host.send({c, 1'b1}, 9, 1'b0);
    u_host.done();
  endtask : cmd
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({dat_oe_n, flag_oe_n, flag_o}, 3'b110);
    chk({tone_p, tone_n, pwr_dn, ext_clk, test_m, common}, 13'h0400);
  endtask : t_reset
  task automatic t_abort();
    u_host.send(9'h004, 3, 1'b0);
    u_host.send(9'h01C, 5, 1'b0);
    u_host.done();
    cmd(8'h1C);
    chk({ext_clk, test_m}, 2'b10);
    cmd(8'hE0);
    chk({ext_clk, test_m}, 2'b11);
    cmd(8'hE3);
    cmd(8'h18);
    chk({ext_clk, test_m}, 2'b00);
  endtask : t_abort
  task automatic t_mem();
    logic [11:0] b;
    logic [7:0] e47;
    logic [7:0] e0;
    e47 = 8'h5A;
    e0 = 8'h93;
    u_host.send(9'h005, 3, 1'b0);
    u_host.send(9'd94, 7, 1'b0);
    u_host.send(9'h00A, 4, 1'b1);
    u_host.send(9'h005, 4, 1'b1);
    u_host.send(9'h003, 4, 1'b1);
    u_host.done();
    u_host.send(9'h005, 3, 1'b0);
    u_host.send(9'h001, 7, 1'b0);
    for (int i = 0; i < 4; i++) begin
      u_host.rd(b[i]);
    end
    chk({dat_oe_n, b[3:0]}, 5'h10);
    u_host.send(9'h009, 4, 1'b1);
    u_host.done();
    u_host.send(9'h006, 3, 1'b0);
    u_host.send(9'd94, 7, 1'b0);
    for (int i = 0; i < 12; i++) begin
      u_host.rd(b[i]);
    end
    chk(dat_oe_n, 1'b0);
    u_host.done();
    chk(b, 12'h35A);
    chk(dat_oe_n, 1'b1);
    cmd(8'h01);
    cmd(8'h03);
    for (int k = 0; k < 8; k++) begin
      await(16'hFF00, {8'h01 << k, 8'h00}, 2100);
      chk({seg[47], seg[0]}, {e47[k], e0[k]});
    end
  endtask : t_mem
  task automatic t_tone();
    for (int i = 0; i < 2; i++) begin
      cmd(i ? 8'h60 : 8'h40);
      cmd(8'h09);
      span(16'h0040, 16'h0040, (i ? slcd_pkg::LOW_HALF_TICKS : slcd_pkg::HIGH_HALF_TICKS) * TICK);
      cmd(8'h08);
      chk({tone_p, tone_n}, 2'b00);
    end
  endtask : t_tone
  task automatic t_flag();
    cmd(8'h07);
    cmd(8'h06);
    chk(flag_oe_n, 1'b1);
    cmd(8'h88);
    for (int r = 7; r > 5; r--) begin
      cmd({5'b1010_0, 3'(r)});
      span(16'h0080, 16'h0000, 128 * (1 << (7 - r)) * TICK);
    end
    cmd(8'hA7);
    cmd(8'h0E);
    cmd(8'h07);
    chk(flag_oe_n, 1'b1);
    repeat (4000) @(negedge clk_sys);
    chk(flag_oe_n, 1'b1);
    await(16'h0080, 16'h0000, 300);
    cmd(8'h0C);
    chk(flag_oe_n, 1'b0);
    cmd(8'h80);
    chk(flag_oe_n, 1'b1);
    cmd(8'h0E);
    cmd(8'h88);
    chk(flag_oe_n, 1'b1);
  endtask : t_flag
  task automatic t_down();
    cmd(8'h09);
    cmd(8'h02);
    chk(pwr_dn, 1'b0);
    cmd(8'h00);
    chk({pwr_dn, tone_p, tone_n, common}, 11'h400);
  endtask : t_down
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    err_total = 0;
    n_compared = 0;
    arst_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    t_reset();
    t_abort();
    t_mem();
    t_tone();
    t_flag();
    t_down();
    end_sim();
  end
endmodule : tb_slcd_ctrl
bind slcd_ctrl slcd_ctrl_props #(.OSC_TICK_CYCLES(OSC_TICK_CYCLES)) u_props (.CLK_SYS, .ARST_N, .SELECT_N,
  .READ_STROBE_N, .DATA_OE_N, .FLAG_O, .FLAG_OE_N, .TONE_OUT_P, .TONE_OUT_N, .COMMON_LINES, .POWER_DOWN,
  .EXT_CLK_SEL, .TEST_MODE);
